//--- verilog/csw_pkg.sv
// Constants for the clock switch and fail-safe monitor block
package csw_pkg;
	// Register byte offsets
	localparam logic [3:0] OFF_OSC  = 4'h0;
	localparam logic [3:0] OFF_MULT = 4'h4;
	localparam logic [3:0] OFF_TRIM = 4'h8;
	localparam logic [3:0] OFF_KEY  = 4'hC;
	// Control register field positions
	localparam int P_CUR     = 12;
	localparam int P_NSEL    = 8;
	localparam int P_CLOCK_CONFIG_LOCK = 7;
	localparam int P_LOCK    = 5;
	localparam int P_CF      = 3;
	localparam int P_SECEN   = 1;
	localparam int P_REQ     = 0;
	localparam int B_HI      = 1;
	localparam int B_LO      = 0;
	// Field widths, reset values and the PLL factor offset
	localparam int SRC_W  = 3;
	localparam int MULT_W = 9;
	localparam int TRIM_W = 6;
	localparam logic [8:0] MULT_RESET  = 9'h030;
	localparam logic [9:0] MULT_OFFSET = 10'h002;
	localparam logic [5:0] TRIM_RESET  = 6'h00;
	// Unlock keys, values arbitrary
	localparam logic [7:0] KEY_FIRST = 8'hA5;
	localparam logic [7:0] KEY_HI    = 8'h5A;
	localparam logic [7:0] KEY_LO    = 8'h3C;
	// Source codes
	localparam logic [2:0] SRC_FRC    = 3'h0;
	localparam logic [2:0] SRC_INTERNAL_RC_WITH_PLL = 3'h1;
	localparam logic [2:0] SRC_PRI    = 3'h2;
	localparam logic [2:0] SRC_PRIPLL = 3'h3;
	localparam logic [2:0] SRC_SEC    = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_RC   = 3'h5;
	localparam logic [2:0] SRC_DIV16  = 3'h6;
	localparam logic [2:0] SRC_DIVN   = 3'h7;
	// Oscillator enable vector bits
	localparam int E_FRC  = 0;
	localparam int E_LOW_POWER_RC = 1;
	localparam int E_PRI  = 2;
	localparam int E_SEC  = 3;
	localparam int E_PLL  = 4;
	localparam int EN_W   = 5;
	// Timing counts
	localparam logic [3:0] SETTLE_CYCLES = 4'hA;
	localparam logic [1:0] BOOT_CYCLES   = 2'h3; // Third edge sees synced straps
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SETTLE} csw_state_t;
endpackage

//--- verilog/csw_clock_switch.sv
// Clock source switch sequencer, PLL and RC trim registers, fail-safe monitor
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module csw_clock_switch #(
	parameter int FAIL_LOW_POWER_RC_CYCLES = 4,
	parameter int FAIL_W           = 8
) (
	// Clock and resets
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	input  wire logic        WARM_RESET_I,
	// Avalon-MM slave
	input  wire logic [3:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	// Configuration straps
	input  wire logic        SWITCH_ENABLE_CFG_I,
	input  wire logic        SWITCH_LOCKABLE_CFG_I,
	input  wire logic [2:0]  INITIAL_SOURCE_CFG_I,
	input  wire logic [1:0]  PRIMARY_SUBMODE_CFG_I,
	// Oscillator status and clocks from outside
	input  wire logic        PRI_READY_I,
	input  wire logic        SEC_READY_I,
	input  wire logic        PLL_LOCK_I,
	input  wire logic        WATCHDOG_EN_I,
	input  wire logic        SLEEP_I,
	input  wire logic        NEW_CLK_I,
	input  wire logic        SYS_CLK_I,
	input  wire logic        LOW_POWER_RC_I,
	// Oscillator controls
	output logic             FRC_EN_O,
	output logic             LOW_POWER_RC_EN_O,
	output logic             PRI_EN_O,
	output logic             SEC_EN_O,
	output logic             PLL_EN_O,
	output logic [2:0]       SYS_CLK_SEL_O,
	output logic [2:0]       TARGET_SEL_O,
	output logic [1:0]       PRIMARY_SUBMODE_O,
	output logic [8:0]       PLL_MULT_CODE_O,
	output logic [9:0]       PLL_FACTOR_O,
	output logic [5:0]       RC_TRIM_CODE_O,
	output logic             SWITCH_BUSY_O,
	output logic             CLOCK_FAIL_TRAP_O
);
	localparam int SYNC_W = 15;

	typedef struct packed {
		logic [SYNC_W-1:0]  sync1;
		logic [SYNC_W-1:0]  sync2;
		logic [2:0]         last;
		logic [1:0]         boot;
		logic [2:0]         cur;
		logic [2:0]         nsel;
		logic [2:0]         target;
		logic               clock_config_lock;
		logic               sec_en;
		logic               req;
		logic               cf;
		logic               lockf;
		logic [8:0]         mult;
		logic [5:0]         trim;
		logic               perm_hi;
		logic               perm_lo;
		logic               key_stage;
		csw_pkg::csw_state_t state;
		logic [3:0]         settle;
		logic [FAIL_W-1:0]  fail_cnt;
		logic               ack;
		logic [31:0]        rdata;
		logic               trap;
		logic [4:0]         en;
	} csw_regs_t;

	csw_regs_t s_reg;
	csw_regs_t s_next;

	// Synchronised pin view
	logic       cfg_sw_n;
	logic       cfg_lockable;
	logic [2:0] cfg_init;
	logic [1:0] cfg_submode;
	logic       pri_rdy;
	logic       sec_rdy;
	logic       pll_lock;
	logic       wdt_en;
	logic       sleep;
	logic       new_clk;
	logic       sys_clk;
	logic       low_power_rc_clk;
	assign {cfg_sw_n, cfg_lockable, cfg_init, cfg_submode, pri_rdy, sec_rdy,
		pll_lock, wdt_en, sleep, new_clk, sys_clk, low_power_rc_clk} = s_reg.sync2;

	// Mode decode
	logic sw_en;
	logic fail_safe_monitor_en;
	logic locked;
	logic booted;
	assign sw_en   = ~cfg_sw_n;
	assign fail_safe_monitor_en = sw_en & ~cfg_lockable;
	assign locked  = s_reg.clock_config_lock & cfg_lockable;
	assign booted  = (s_reg.boot == csw_pkg::BOOT_CYCLES);

	// Edges seen after the synchroniser, so slow clocks only
	logic new_edge;
	logic sys_edge;
	logic low_power_rc_edge;
	assign new_edge  = new_clk & ~s_reg.last[2];
	assign sys_edge  = sys_clk & ~s_reg.last[1];
	assign low_power_rc_edge = low_power_rc_clk & ~s_reg.last[0];

	// Oscillators a source code needs running
	// source code decode
	function automatic logic [4:0] needs(input logic [2:0] src);
		logic [4:0] e;
		e = '0;
		unique case (src)
			csw_pkg::SRC_INTERNAL_RC_WITH_PLL: begin
				e[csw_pkg::E_FRC] = 1'b1;
				e[csw_pkg::E_PLL] = 1'b1;
			end
			csw_pkg::SRC_PRI:    e[csw_pkg::E_PRI] = 1'b1;
			csw_pkg::SRC_PRIPLL: begin
				e[csw_pkg::E_PRI] = 1'b1;
				e[csw_pkg::E_PLL] = 1'b1;
			end
			csw_pkg::SRC_SEC:    e[csw_pkg::E_SEC] = 1'b1;
			csw_pkg::SRC_LOW_POWER_RC:   e[csw_pkg::E_LOW_POWER_RC] = 1'b1;
			default:             e[csw_pkg::E_FRC] = 1'b1;
		endcase
		return e;
	endfunction

	// Bus decode
	logic        bus_req;
	logic        wr_go;
	logic        sel_osc;
	logic        sel_mult;
	logic        sel_trim;
	logic        sel_key;
	logic [31:0] rd_mux;
	logic [4:0]  tgt_need;
	logic        tgt_ready;
	assign bus_req  = AVS_READ_I | AVS_WRITE_I;
	assign wr_go    = AVS_WRITE_I & s_reg.ack;
	assign sel_osc  = (AVS_ADDRESS_I[3:2] == csw_pkg::OFF_OSC[3:2]);
	assign sel_mult = (AVS_ADDRESS_I[3:2] == csw_pkg::OFF_MULT[3:2]);
	assign sel_trim = (AVS_ADDRESS_I[3:2] == csw_pkg::OFF_TRIM[3:2]);
	assign sel_key  = (AVS_ADDRESS_I[3:2] == csw_pkg::OFF_KEY[3:2]);
	// One wait state on every access
	assign AVS_WAITREQUEST_O = bus_req & ~s_reg.ack;

	assign tgt_need  = needs(s_reg.target);
	assign tgt_ready = (~tgt_need[csw_pkg::E_PRI] | pri_rdy)
		& (~tgt_need[csw_pkg::E_SEC] | sec_rdy)
		& (~tgt_need[csw_pkg::E_PLL] | pll_lock);

	// Read mux, reserved bits zero
	always_comb begin
		rd_mux = '0;
		if (sel_osc) begin
			rd_mux[csw_pkg::P_CUR +: csw_pkg::SRC_W]  = s_reg.cur;
			rd_mux[csw_pkg::P_NSEL +: csw_pkg::SRC_W] = s_reg.nsel;
			rd_mux[csw_pkg::P_CLOCK_CONFIG_LOCK] = s_reg.clock_config_lock;
			rd_mux[csw_pkg::P_LOCK]    = s_reg.lockf;
			rd_mux[csw_pkg::P_CF]      = s_reg.cf;
			rd_mux[csw_pkg::P_SECEN]   = s_reg.sec_en;
			rd_mux[csw_pkg::P_REQ]     = s_reg.req;
		end else if (sel_mult) begin
			rd_mux[csw_pkg::MULT_W-1:0] = s_reg.mult;
		end else if (sel_trim) begin
			rd_mux[csw_pkg::TRIM_W-1:0] = s_reg.trim;
		end
	end

	// Next-state logic
	always_comb begin
		s_next       = s_reg;
		s_next.trap  = 1'b0;
		s_next.sync1 = {SWITCH_ENABLE_CFG_I, SWITCH_LOCKABLE_CFG_I, INITIAL_SOURCE_CFG_I,
			PRIMARY_SUBMODE_CFG_I, PRI_READY_I, SEC_READY_I, PLL_LOCK_I, WATCHDOG_EN_I,
			SLEEP_I, NEW_CLK_I, SYS_CLK_I, LOW_POWER_RC_I};
		s_next.sync2 = s_reg.sync1;
		s_next.last  = {new_clk, sys_clk, low_power_rc_clk};
		s_next.ack   = bus_req & ~s_reg.ack;
		if (AVS_READ_I & ~s_reg.ack) begin
			s_next.rdata = rd_mux;
		end
		s_next.lockf = pll_lock & s_reg.en[csw_pkg::E_PLL];

		// Straps settle through the synchroniser before loading
		if (!booted) begin
			s_next.boot = s_reg.boot + 2'h1;
			s_next.cur  = cfg_init;
			s_next.nsel = cfg_init;
		end

		// Unlock keys; any other write drops a half-done sequence
		if (wr_go & ~sel_key) begin
			s_next.key_stage = 1'b0;
		end
		if (wr_go & sel_key & AVS_BYTEENABLE_I[0]) begin
			s_next.key_stage = 1'b0;
			if (!s_reg.key_stage) begin
				s_next.key_stage = (AVS_WRITEDATA_I[7:0] == csw_pkg::KEY_FIRST);
			end else if (AVS_WRITEDATA_I[7:0] == csw_pkg::KEY_HI) begin
				s_next.perm_hi = 1'b1;
			end else if (AVS_WRITEDATA_I[7:0] == csw_pkg::KEY_LO) begin
				s_next.perm_lo = 1'b1;
			end
		end

		if (wr_go & sel_osc & AVS_BYTEENABLE_I[csw_pkg::B_HI]) begin
			s_next.perm_hi = 1'b0;
			if (s_reg.perm_hi & ~locked & booted) begin
				s_next.nsel = AVS_WRITEDATA_I[csw_pkg::P_NSEL +: csw_pkg::SRC_W];
			end
		end
		if (wr_go & sel_osc & AVS_BYTEENABLE_I[csw_pkg::B_LO]) begin
			s_next.perm_lo = 1'b0;
			if (s_reg.perm_lo) begin
				if (!locked) begin
					s_next.clock_config_lock = AVS_WRITEDATA_I[csw_pkg::P_CLOCK_CONFIG_LOCK];
				end
				s_next.sec_en = AVS_WRITEDATA_I[csw_pkg::P_SECEN];
				if (!AVS_WRITEDATA_I[csw_pkg::P_CF]) begin
					s_next.cf = 1'b0;
				end
				if (AVS_WRITEDATA_I[csw_pkg::P_REQ] & sw_en & booted) begin
					s_next.req = 1'b1;
				end
			end
		end

		if (wr_go & sel_mult & ~locked) begin
			if (AVS_BYTEENABLE_I[0]) begin
				s_next.mult[7:0] = AVS_WRITEDATA_I[7:0];
			end
			if (AVS_BYTEENABLE_I[1]) begin
				s_next.mult[8] = AVS_WRITEDATA_I[8];
			end
		end
		if (wr_go & sel_trim & AVS_BYTEENABLE_I[0]) begin
			s_next.trim = AVS_WRITEDATA_I[csw_pkg::TRIM_W-1:0];
		end

		unique case (s_reg.state)
			csw_pkg::ST_IDLE: begin
				if (s_reg.req) begin
					if (s_reg.nsel == s_reg.cur) begin
						s_next.req = 1'b0;
					end else begin
						s_next.target = s_reg.nsel;
						s_next.lockf  = 1'b0;
						s_next.cf     = 1'b0;
						s_next.state  = csw_pkg::ST_WAIT;
					end
				end
			end
			csw_pkg::ST_WAIT: begin
				if (tgt_ready) begin
					s_next.settle = '0;
					s_next.state  = csw_pkg::ST_SETTLE;
				end
			end
			csw_pkg::ST_SETTLE: begin
				if (new_edge) begin
					if (s_reg.settle == csw_pkg::SETTLE_CYCLES - 4'h1) begin
						s_next.cur   = s_reg.target;
						s_next.req   = 1'b0;
						s_next.state = csw_pkg::ST_IDLE;
					end else begin
						s_next.settle = s_reg.settle + 4'h1;
					end
				end
			end
		endcase

		if (!sw_en) begin
			if (booted) begin
				s_next.cur = cfg_init;
			end
			s_next.req   = 1'b0;
			s_next.state = csw_pkg::ST_IDLE;
		end

		// A warm reset aborts the sequence but keeps the settings
		if (WARM_RESET_I) begin
			s_next.req       = 1'b0;
			s_next.state     = csw_pkg::ST_IDLE;
			s_next.perm_hi   = 1'b0;
			s_next.perm_lo   = 1'b0;
			s_next.key_stage = 1'b0;
			s_next.fail_cnt  = '0;
		end

		// count RC edges between system clock edges
		if (!fail_safe_monitor_en | sleep | !booted | sys_edge) begin
			s_next.fail_cnt = '0;
		end else if (low_power_rc_edge) begin
			if (s_reg.fail_cnt == FAIL_W'(FAIL_LOW_POWER_RC_CYCLES - 1)) begin
				s_next.fail_cnt = '0;
				s_next.trap     = 1'b1;
				s_next.cf       = 1'b1;
				s_next.req      = 1'b0;
				s_next.state    = csw_pkg::ST_IDLE;
				s_next.cur      = csw_pkg::SRC_FRC;
				if (s_reg.cur == csw_pkg::SRC_INTERNAL_RC_WITH_PLL || s_reg.cur == csw_pkg::SRC_PRIPLL) begin
					s_next.cur = csw_pkg::SRC_INTERNAL_RC_WITH_PLL;
				end
			end else begin
				s_next.fail_cnt = s_reg.fail_cnt + FAIL_W'(1);
			end
		end

		s_next.en = needs(s_next.cur);
		if (s_next.state != csw_pkg::ST_IDLE) begin
			s_next.en = s_next.en | needs(s_next.target);
		end
		if (s_next.sec_en) begin
			s_next.en[csw_pkg::E_SEC] = 1'b1;
		end
		if (wdt_en | (fail_safe_monitor_en & ~sleep)) begin
			s_next.en[csw_pkg::E_LOW_POWER_RC] = 1'b1;
		end
	end

	// State register, power-on reset only
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			s_reg       <= '0;
			s_reg.mult  <= csw_pkg::MULT_RESET;
			s_reg.trim  <= csw_pkg::TRIM_RESET;
			s_reg.state <= csw_pkg::ST_IDLE;
			s_reg.en    <= 5'h01;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign AVS_READDATA_O    = s_reg.rdata;
	assign FRC_EN_O          = s_reg.en[csw_pkg::E_FRC];
	assign LOW_POWER_RC_EN_O         = s_reg.en[csw_pkg::E_LOW_POWER_RC];
	assign PRI_EN_O          = s_reg.en[csw_pkg::E_PRI];
	assign SEC_EN_O          = s_reg.en[csw_pkg::E_SEC];
	assign PLL_EN_O          = s_reg.en[csw_pkg::E_PLL];
	assign SYS_CLK_SEL_O     = s_reg.cur;
	assign TARGET_SEL_O      = s_reg.target;
	assign PRIMARY_SUBMODE_O = cfg_submode;
	assign PLL_MULT_CODE_O   = s_reg.mult;
	assign PLL_FACTOR_O      = {1'b0, s_reg.mult} + csw_pkg::MULT_OFFSET;
	assign RC_TRIM_CODE_O    = s_reg.trim;
	assign SWITCH_BUSY_O     = (s_reg.state != csw_pkg::ST_IDLE);
	assign CLOCK_FAIL_TRAP_O = s_reg.trap;
endmodule

//--- test/csw_monitor.sv
// Port-level checks for the clock switch block
`timescale 1ns/1ps
module csw_monitor (
	input wire logic       CLK_I,
	input wire logic       RESET_I,
	input wire logic       WARM_RESET_I,
	input wire logic       AVS_READ_I,
	input wire logic       AVS_WRITE_I,
	input wire logic       AVS_WAITREQUEST_O,
	input wire logic       SWITCH_ENABLE_CFG_I,
	input wire logic       SWITCH_LOCKABLE_CFG_I,
	input wire logic [2:0] INITIAL_SOURCE_CFG_I,
	input wire logic [1:0] PRIMARY_SUBMODE_CFG_I,
	input wire logic       WATCHDOG_EN_I,
	input wire logic       SLEEP_I,
	input wire logic       LOW_POWER_RC_EN_O,
	input wire logic [2:0] SYS_CLK_SEL_O,
	input wire logic [2:0] TARGET_SEL_O,
	input wire logic [1:0] PRIMARY_SUBMODE_O,
	input wire logic [8:0] PLL_MULT_CODE_O,
	input wire logic [9:0] PLL_FACTOR_O,
	input wire logic       SWITCH_BUSY_O,
	input wire logic       CLOCK_FAIL_TRAP_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	// Straps held long enough to pass the sync flops
	sequence s_off;
		SWITCH_ENABLE_CFG_I [*6];
	endsequence
	sequence s_fsm_on;
		(!SWITCH_ENABLE_CFG_I && !SWITCH_LOCKABLE_CFG_I && !SLEEP_I) [*6];
	endsequence
	sequence s_done;
		$fell(SWITCH_BUSY_O) && !CLOCK_FAIL_TRAP_O && !$past(WARM_RESET_I);
	endsequence
	factor_plus_two_a: assert property (
		PLL_FACTOR_O == {1'b0, PLL_MULT_CODE_O} + 10'h002) else $error("factor not code plus two");
	one_wait_a: assert property (
		(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
		else $error("bus stalled beyond one cycle");
	off_idle_a: assert property (
		s_off |-> !SWITCH_BUSY_O && !CLOCK_FAIL_TRAP_O) else $error("active while strapped off");
	off_source_a: assert property (
		(SWITCH_ENABLE_CFG_I && $stable(INITIAL_SOURCE_CFG_I)) [*6] |->
		SYS_CLK_SEL_O == INITIAL_SOURCE_CFG_I) else $error("source differs from strap");
	submode_a: assert property (
		$stable(PRIMARY_SUBMODE_CFG_I) [*5] |-> PRIMARY_SUBMODE_O == PRIMARY_SUBMODE_CFG_I)
		else $error("primary submode not from strap");
	low_power_rc_fsm_a: assert property (
		s_fsm_on |-> LOW_POWER_RC_EN_O) else $error("low-power RC off with monitor on");
	low_power_rc_wdog_a: assert property (
		WATCHDOG_EN_I [*5] |-> LOW_POWER_RC_EN_O) else $error("low-power RC off with watchdog on");
	trap_pulse_a: assert property (
		CLOCK_FAIL_TRAP_O |=> !CLOCK_FAIL_TRAP_O) else $error("trap longer than one cycle");
	fallback_a: assert property (
		CLOCK_FAIL_TRAP_O |-> SYS_CLK_SEL_O == (($past(SYS_CLK_SEL_O) == 3'h1 ||
		$past(SYS_CLK_SEL_O) == 3'h3) ? 3'h1 : 3'h0)) else $error("wrong fallback source");
	handover_a: assert property (
		s_done |-> SYS_CLK_SEL_O == $past(TARGET_SEL_O)) else $error("handover source wrong");
endmodule
bind csw_clock_switch csw_monitor csw_monitor_inst (.*);

//--- test/csw_osc_model.sv
// Oscillator stand-in: start-up timer, PLL lock and free-running clocks
`timescale 1ns/1ps
module csw_osc_model #(
	parameter int PRI_DELAY = 20,
	parameter int PLL_DELAY = 40
) (
	// Bench clock and enables
	input  wire logic clk_i,
	input  wire logic pri_en_i,
	input  wire logic sec_en_i,
	input  wire logic pll_en_i,
	input  wire logic sys_stop_i,
	// Status and clocks
	output logic      pri_ready_o,
	output logic      sec_ready_o,
	output logic      pll_lock_o,
	output logic      new_clk_o,
	output logic      sys_clk_o,
	output logic      low_power_rc_o
);
	logic [3:0] cnt = 4'h0;
	int         pri_t = 0;
	int         pll_t = 0;
	// Ready rises just after a new-clock fall, so no edge hides in sync delay
	always @(posedge clk_i) begin
		cnt <= cnt + 4'h1;
		pri_t <= pri_en_i ? pri_t + 1 : 0;
		pll_t <= pll_en_i ? pll_t + 1 : 0;
		pri_ready_o <= pri_en_i && (pri_ready_o || (pri_t >= PRI_DELAY && cnt == 4'h1));
		pll_lock_o <= pll_en_i && (pll_lock_o || (pll_t >= PLL_DELAY && cnt == 4'h1));
		sec_ready_o <= sec_en_i;
	end
	// Slow clocks well under the sampling limit
	assign new_clk_o = cnt[3];
	assign low_power_rc_o = cnt[3];
	assign sys_clk_o = sys_stop_i ? 1'b0 : cnt[1];
endmodule

//--- test/tb_top.sv
// Self-checking bench for the clock switch block
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] M_ALL = 32'hFFFFFFFF;
	logic        CLK_I, RESET_I, WARM_RESET_I, AVS_READ_I, AVS_WRITE_I, SWITCH_ENABLE_CFG_I;
	logic        SWITCH_LOCKABLE_CFG_I, WATCHDOG_EN_I, SLEEP_I, AVS_WAITREQUEST_O, PRI_READY_I;
	logic        SEC_READY_I, PLL_LOCK_I, NEW_CLK_I, SYS_CLK_I, LOW_POWER_RC_I, FRC_EN_O;
	logic        LOW_POWER_RC_EN_O, PRI_EN_O, SEC_EN_O, PLL_EN_O, SWITCH_BUSY_O, CLOCK_FAIL_TRAP_O;
	logic        sys_stop, nclk_q;
	logic [3:0]  AVS_ADDRESS_I, AVS_BYTEENABLE_I;
	logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, rd;
	logic [2:0]  INITIAL_SOURCE_CFG_I, SYS_CLK_SEL_O, TARGET_SEL_O;
	logic [1:0]  PRIMARY_SUBMODE_CFG_I, PRIMARY_SUBMODE_O;
	logic [8:0]  PLL_MULT_CODE_O, code;
	logic [9:0]  PLL_FACTOR_O;
	logic [5:0]  RC_TRIM_CODE_O, trim;
	int          fail_count, tests_run, k;
	wire         rdy = PRI_READY_I && (PLL_LOCK_I || !PLL_EN_O);
	csw_clock_switch #(.FAIL_LOW_POWER_RC_CYCLES(4), .FAIL_W(8)) csw_clock_switch_inst (.*);
	csw_osc_model csw_osc_model_inst (.clk_i(CLK_I), .pri_en_i(PRI_EN_O), .sec_en_i(SEC_EN_O),
		.pll_en_i(PLL_EN_O), .sys_stop_i(sys_stop), .pri_ready_o(PRI_READY_I),
		.sec_ready_o(SEC_READY_I), .pll_lock_o(PLL_LOCK_I), .new_clk_o(NEW_CLK_I),
		.sys_clk_o(SYS_CLK_I), .low_power_rc_o(LOW_POWER_RC_I));
	always #5 CLK_I = ~CLK_I;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= d;
		AVS_BYTEENABLE_I <= be;
		AVS_WRITE_I <= w;
		AVS_READ_I <= !w;
		// Waitrequest seen mid-cycle stands until the coming rising edge
		do begin
			@(negedge CLK_I);
		end while (AVS_WAITREQUEST_O !== 1'b0);
		// Answer edge: read data still stands here, then release
		@(posedge CLK_I);
		rd = AVS_READDATA_O;
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I <= 1'b0;
		@(posedge CLK_I);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		check(rd & m, e);
	endtask
	// Key pair, then one write to the chosen control byte
	task automatic ctl(input logic hi, input logic [7:0] v);
		bus(1'b1, csw_pkg::OFF_KEY, {24'h0, csw_pkg::KEY_FIRST}, 4'h1);
		bus(1'b1, csw_pkg::OFF_KEY, {24'h0, hi ? csw_pkg::KEY_HI : csw_pkg::KEY_LO}, 4'h1);
		bus(1'b1, csw_pkg::OFF_OSC, hi ? {16'h0, v, 8'h00} : {24'h0, v}, hi ? 4'h2 : 4'h1);
	endtask
	task automatic switch_to(input logic [2:0] s);
		ctl(1'b1, {5'h00, s});
		ctl(1'b0, 8'h01);
	endtask
	task automatic por(input logic en, input logic lk, input logic [2:0] src);
		RESET_I <= 1'b1;
		WATCHDOG_EN_I <= 1'b0;
		SWITCH_ENABLE_CFG_I <= en;
		SWITCH_LOCKABLE_CFG_I <= lk;
		INITIAL_SOURCE_CFG_I <= src;
		PRIMARY_SUBMODE_CFG_I <= 2'($urandom);
		repeat (16) @(posedge CLK_I);
		RESET_I <= 1'b0;
		repeat (4) @(posedge CLK_I);
	endtask
	// Counts new-clock rises once the target is ready, until handover
	task automatic wait_idle();
		int n;
		n = 0;
		k = 0;
		// Busy rises on the edge the caller returns on, so look only after it
		do begin
			@(negedge CLK_I);
			n++;
			if (rdy === 1'b1 && NEW_CLK_I === 1'b1 && nclk_q === 1'b0) k++;
			nclk_q = NEW_CLK_I;
		end while (SWITCH_BUSY_O !== 1'b0 && n < 3000);
		if (n >= 3000) fail_count++;
		@(posedge CLK_I);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Whole run needs about a thousand cycles
	initial begin
		repeat (40000) @(posedge CLK_I);
		fail_count++;
		report_and_stop();
	end
	initial begin
		CLK_I = 1'b0;
		{WARM_RESET_I, AVS_READ_I, AVS_WRITE_I, SLEEP_I, sys_stop, nclk_q} = 6'h00;
		{AVS_ADDRESS_I, AVS_BYTEENABLE_I, AVS_WRITEDATA_I} = 40'h0;
		fail_count = 0;
		tests_run = 0;
		void'($urandom(32'h98E21F87));
		por(1'b1, 1'b0, csw_pkg::SRC_PRI);
		rchk(csw_pkg::OFF_MULT, M_ALL, {23'h0, csw_pkg::MULT_RESET});
		rchk(csw_pkg::OFF_TRIM, M_ALL, 32'h0);
		// Boundary codes first, then random ones; upper trim bits must drop
		for (int i = 0; i < 6; i++) begin
			code = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($urandom);
			trim = (i == 0) ? 6'h20 : (i == 1) ? 6'h1F : 6'($urandom);
			bus(1'b1, csw_pkg::OFF_MULT, {23'h0, code}, 4'hF);
			bus(1'b1, csw_pkg::OFF_TRIM, {16'h0, 10'h3FF, trim}, 4'hF);
			rchk(csw_pkg::OFF_MULT, M_ALL, {23'h0, code});
			check(32'(PLL_FACTOR_O), 32'(code) + 32'h2);
			check(32'(PLL_MULT_CODE_O), 32'(code));
			rchk(csw_pkg::OFF_TRIM, M_ALL, {26'h0, trim});
			check(32'(RC_TRIM_CODE_O), 32'(trim));
		end
		// Warm reset keeps settings
		WARM_RESET_I <= 1'b1;
		repeat (6) @(posedge CLK_I);
		WARM_RESET_I <= 1'b0;
		WATCHDOG_EN_I <= 1'b1;
		@(posedge CLK_I);
		rchk(csw_pkg::OFF_MULT, M_ALL, {23'h0, code});
		rchk(csw_pkg::OFF_TRIM, M_ALL, {26'h0, trim});
		check(32'(LOW_POWER_RC_EN_O), 32'h1);
		switch_to(csw_pkg::SRC_FRC);
		rchk(csw_pkg::OFF_OSC, 32'h7001, {17'h0, csw_pkg::SRC_PRI, 12'h0});
		check(32'(SWITCH_BUSY_O), 32'h0);
		// Lockable strap: lock bit freezes new source and multiplier; boot loads strap
		por(1'b0, 1'b1, csw_pkg::SRC_PRI);
		rchk(csw_pkg::OFF_MULT, M_ALL, {23'h0, csw_pkg::MULT_RESET});
		ctl(1'b0, 8'h80);
		ctl(1'b1, {5'h00, csw_pkg::SRC_SEC});
		bus(1'b1, csw_pkg::OFF_MULT, 32'h00000005, 4'hF);
		rchk(csw_pkg::OFF_OSC, 32'h7780, {17'h0, csw_pkg::SRC_PRI, 1'b0, csw_pkg::SRC_PRI, 8'h80});
		rchk(csw_pkg::OFF_MULT, M_ALL, {23'h0, csw_pkg::MULT_RESET});
		// Switching and monitor on
		por(1'b0, 1'b0, csw_pkg::SRC_FRC);
		bus(1'b1, csw_pkg::OFF_OSC, 32'h00000200, 4'h2);
		rchk(csw_pkg::OFF_OSC, 32'h0700, 32'h0);
		switch_to(csw_pkg::SRC_FRC);
		repeat (4) @(posedge CLK_I);
		rchk(csw_pkg::OFF_OSC, 32'h0001, 32'h0);
		switch_to(csw_pkg::SRC_PRI);
		rchk(csw_pkg::OFF_OSC, 32'h0029, 32'h0001);
		check(32'(PRI_EN_O), 32'h1);
		wait_idle();
		check(k, 10);
		rchk(csw_pkg::OFF_OSC, 32'h7001, {17'h0, csw_pkg::SRC_PRI, 12'h0});
		check(32'(FRC_EN_O), 32'h0);
		check(32'(LOW_POWER_RC_EN_O), 32'h1);
		switch_to(csw_pkg::SRC_PRIPLL);
		wait_idle();
		check(k, 10);
		rchk(csw_pkg::OFF_OSC, 32'h7020, {17'h0, csw_pkg::SRC_PRIPLL, 12'h020});
		// Stop the system clock and wait for the trap
		sys_stop <= 1'b1;
		k = 0;
		while (CLOCK_FAIL_TRAP_O !== 1'b1 && k < 500) begin
			@(negedge CLK_I);
			k++;
		end
		sys_stop <= 1'b0;
		check(32'(k < 500), 32'h1);
		check(32'(SYS_CLK_SEL_O), 32'(csw_pkg::SRC_INTERNAL_RC_WITH_PLL));
		@(posedge CLK_I);
		rchk(csw_pkg::OFF_OSC, 32'h0008, 32'h0008);
		ctl(1'b0, 8'h08);
		rchk(csw_pkg::OFF_OSC, 32'h0008, 32'h0008);
		ctl(1'b0, 8'h02);
		rchk(csw_pkg::OFF_OSC, 32'h0008, 32'h0);
		check(32'(SEC_EN_O), 32'h1);
		// Sleep: monitor stands still, so a stopped clock is no failure
		SLEEP_I <= 1'b1;
		sys_stop <= 1'b1;
		repeat (150) @(posedge CLK_I);
		check(32'(LOW_POWER_RC_EN_O), 32'h0);
		sys_stop <= 1'b0;
		SLEEP_I <= 1'b0;
		@(posedge CLK_I);
		rchk(csw_pkg::OFF_OSC, 32'h0008, 32'h0);
		report_and_stop();
	end
endmodule
